// file: rtl/init_misc_control_regs.sv
module init_misc_control_regs (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        clk2x_en_i,
  input  wire logic        osc_nand_i,
  input  wire logic        osc_nor_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic [20:19] hw_addr_i,
  input  wire logic [31:0] hw_wdata_i,
  output logic      [31:0] hw_wdata_o,
  input  wire logic [31:0] lfb_wdata_i,
  output logic      [31:0] lfb_wdata_o,
  input  wire logic        blank_i,
  input  wire logic        hsync_i,
  input  wire logic        vsync_i,
  output logic             tv_blank_o,
  output logic             tv_hsync_o,
  output logic             tv_vsync_o,
  output logic             mon_hsync_o,
  output logic             mon_vsync_o,
  output logic             osc_nor_sel_o,
  output logic      [12:0] tile_begin_page_o,
  output logic      [14:0] tile_stride_bytes_o,
  output logic      [6:0]  tiles_x_o,
  output logic             rst_3d_o,
  output logic             rst_host_fifo_o,
  output logic      [3:0]  rst_sub_o,
  output logic      [11:0] y_origin_o
);
  logic [15:0] ref_cnt_r, ref_cnt_nxt;
  logic [11:0] osc_cnt_r, osc_cnt_nxt;
  logic [31:0] mon_r, mon_nxt;
  logic [31:0] tile_r, tile_nxt;
  logic [31:0] misc_r, misc_nxt;
  logic        osc_s1_r, osc_s2_r, osc_s3_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] hw_r, hw_nxt, lfb_r, lfb_nxt;
  logic        osc_sel, osc_rise, mon_en;
  logic [2:0]  stride;

  function automatic logic [31:0] swz(input logic [31:0] d, input logic b, input logic w);
    logic [31:0] t;
    t = b ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    return w ? {t[15:0], t[31:16]} : t;
  endfunction : swz

  // ring oscillator edges are brought in through two flops, the third finds rises
  assign osc_sel  = mon_r[misc_regs_pkg::NOR_SEL_BIT] ? osc_nor_i : osc_nand_i;
  assign osc_rise = osc_s2_r & ~osc_s3_r;
  assign mon_en   = mon_r[misc_regs_pkg::MON_EN_BIT];

  always_comb begin
    mon_nxt  = mon_r;
    tile_nxt = tile_r;
    misc_nxt = misc_r;
    ref_cnt_nxt = ref_cnt_r;
    osc_cnt_nxt = osc_cnt_r;
    if (mon_en) begin
      ref_cnt_nxt = ref_cnt_r + 16'h0001;
      if (osc_rise) osc_cnt_nxt = osc_cnt_r + 12'h001;
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        misc_regs_pkg::SPEED_MON_OFS: mon_nxt = reg_wdata_i;
        misc_regs_pkg::TILE_CFG_OFS:  tile_nxt = reg_wdata_i & misc_regs_pkg::TILE_CFG_MASK;
        misc_regs_pkg::MISC_INIT_OFS: misc_nxt = reg_wdata_i & misc_regs_pkg::MISC_INIT_MASK;
        default: ;
      endcase
    end
    if (mon_nxt[misc_regs_pkg::OSC_CLR_BIT]) osc_cnt_nxt = 12'h000;
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_i) begin
      case (reg_addr_i)
        misc_regs_pkg::SPEED_MON_OFS:
          rdata_nxt = {1'b0, mon_r[30:28], osc_cnt_r, ref_cnt_r};
        misc_regs_pkg::TILE_CFG_OFS:  rdata_nxt = tile_r;
        misc_regs_pkg::MISC_INIT_OFS: rdata_nxt = misc_r;
        default:                      rdata_nxt = 32'h00000000;
      endcase
    end
    hw_nxt  = hw_wdata_i;
    if (hw_addr_i[misc_regs_pkg::ADDR_3D_BIT] | hw_addr_i[misc_regs_pkg::ADDR_2D_BIT]) begin
      hw_nxt = swz(hw_wdata_i, misc_r[misc_regs_pkg::REG_BSWZ_BIT],
                   misc_r[misc_regs_pkg::REG_WSWZ_BIT]);
    end
    lfb_nxt = swz(lfb_wdata_i, misc_r[misc_regs_pkg::LFB_BSWZ_BIT],
                  misc_r[misc_regs_pkg::LFB_WSWZ_BIT]);
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mon_r     <= misc_regs_pkg::SPEED_MON_RST;
      tile_r    <= misc_regs_pkg::TILE_CFG_RST;
      misc_r    <= misc_regs_pkg::MISC_INIT_RST;
      ref_cnt_r <= 16'h0000;
      osc_cnt_r <= 12'h000;
      osc_s1_r  <= 1'b0;
      osc_s2_r  <= 1'b0;
      osc_s3_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      hw_r      <= 32'h00000000;
      lfb_r     <= 32'h00000000;
    end else begin
      mon_r     <= mon_nxt;
      tile_r    <= tile_nxt;
      misc_r    <= misc_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      osc_cnt_r <= osc_cnt_nxt;
      osc_s1_r  <= osc_sel;
      osc_s2_r  <= osc_s1_r;
      osc_s3_r  <= osc_s2_r;
      rdata_r   <= rdata_nxt;
      hw_r      <= hw_nxt;
      lfb_r     <= lfb_nxt;
    end
  end

  assign reg_rdata_o         = rdata_r;
  assign hw_wdata_o          = hw_r;
  assign lfb_wdata_o         = lfb_r;
  assign osc_nor_sel_o       = mon_r[misc_regs_pkg::NOR_SEL_BIT];
  assign tile_begin_page_o   = tile_r[misc_regs_pkg::BEGIN_LSB +: 13];
  assign stride              = tile_r[misc_regs_pkg::STRIDE_LSB +: 3];
  // codes above 4 are undefined; they clamp to 16k
  assign tile_stride_bytes_o = {misc_regs_pkg::STRIDE_1K[4:0], 10'h000}
                               << ((stride > 3'h4) ? 3'h4 : stride);
  assign tiles_x_o           = tile_r[misc_regs_pkg::TILES_X_LSB +: 7];
  assign rst_3d_o            = misc_r[misc_regs_pkg::RST_3D_BIT];
  assign rst_host_fifo_o     = misc_r[misc_regs_pkg::RST_FIFO_BIT];
  assign rst_sub_o           = misc_r[misc_regs_pkg::RST_VID_BIT +: 4];
  assign y_origin_o          = misc_r[misc_regs_pkg::YORG_LSB +: 12];

  sync_delay_line #(.W(1)) u_tv_blank (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .ce_i   (clk2x_en_i),
    .sel_i  (misc_r[misc_regs_pkg::TV_BLANK_LSB +: 3]),
    .d_i    (blank_i),
    .q_o    (tv_blank_o)
  );

  sync_delay_line #(.W(2)) u_tv_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .ce_i   (clk2x_en_i),
    .sel_i  (misc_r[misc_regs_pkg::TV_SYNC_LSB +: 3]),
    .d_i    ({hsync_i, vsync_i}),
    .q_o    ({tv_hsync_o, tv_vsync_o})
  );

  sync_delay_line #(.W(2)) u_mon_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .ce_i   (clk2x_en_i),
    .sel_i  (misc_r[misc_regs_pkg::MON_SYNC_LSB +: 3]),
    .d_i    ({hsync_i, vsync_i}),
    .q_o    ({mon_hsync_o, mon_vsync_o})
  );

  property p_ref_hold;
    @(posedge mclk_i) disable iff (!rstn_i)
      !mon_en |=> ref_cnt_r == $past(ref_cnt_r);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("ref counter moved while off");

  property p_ref_run;
    @(posedge mclk_i) disable iff (!rstn_i)
      mon_en |=> ref_cnt_r == $past(ref_cnt_r) + 16'h0001;
  endproperty
  a_ref_run: assert property (p_ref_run) else $error("ref counter not counting");

  property p_osc_clr;
    @(posedge mclk_i) disable iff (!rstn_i)
      mon_r[misc_regs_pkg::OSC_CLR_BIT] |-> osc_cnt_r == 12'h000;
  endproperty
  a_osc_clr: assert property (p_osc_clr) else $error("osc counter not cleared");

  property p_osc_step;
    @(posedge mclk_i) disable iff (!rstn_i)
      osc_cnt_r != $past(osc_cnt_r) && osc_cnt_r != 12'h000 |-> $past(osc_rise && mon_en);
  endproperty
  a_osc_step: assert property (p_osc_step) else $error("osc counter moved without edge");

  property p_mon_wr;
    @(posedge mclk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == misc_regs_pkg::SPEED_MON_OFS |=> mon_r == $past(reg_wdata_i);
  endproperty
  a_mon_wr: assert property (p_mon_wr) else $error("speed monitor write lost");

  property p_rst3d;
    @(posedge mclk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == misc_regs_pkg::MISC_INIT_OFS |=> rst_3d_o == $past(reg_wdata_i[0]);
  endproperty
  a_rst3d: assert property (p_rst3d) else $error("3d reset does not follow write");

  property p_lfb_bswz;
    @(posedge mclk_i) disable iff (!rstn_i)
      misc_r[31:30] == 2'b01 |=> lfb_wdata_o == {$past(lfb_wdata_i[7:0]), $past(lfb_wdata_i[15:8]),
                                                 $past(lfb_wdata_i[23:16]), $past(lfb_wdata_i[31:24])};
  endproperty
  a_lfb_bswz: assert property (p_lfb_bswz) else $error("lfb byte swizzle wrong");

  property p_reg_wswz;
    @(posedge mclk_i) disable iff (!rstn_i)
      misc_r[3:2] == 2'b10 && hw_addr_i != 2'b00 |=>
        hw_wdata_o == {$past(hw_wdata_i[15:0]), $past(hw_wdata_i[31:16])};
  endproperty
  a_reg_wswz: assert property (p_reg_wswz) else $error("register word swizzle wrong");

  property p_reg_plain;
    @(posedge mclk_i) disable iff (!rstn_i)
      hw_addr_i == 2'b00 |=> hw_wdata_o == $past(hw_wdata_i);
  endproperty
  a_reg_plain: assert property (p_reg_plain) else $error("unqualified write altered");

  property p_lfb_plain;
    @(posedge mclk_i) disable iff (!rstn_i)
      misc_r[31:30] == 2'b00 |=> lfb_wdata_o == $past(lfb_wdata_i);
  endproperty
  a_lfb_plain: assert property (p_lfb_plain) else $error("lfb data altered");

  property p_tile_wr;
    @(posedge mclk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == misc_regs_pkg::TILE_CFG_OFS |=>
        tile_begin_page_o == $past(reg_wdata_i[12:0]) && tiles_x_o == $past(reg_wdata_i[22:16]);
  endproperty
  a_tile_wr: assert property (p_tile_wr) else $error("tile fields do not follow write");

  property p_tile_rsvd;
    @(posedge mclk_i) disable iff (!rstn_i)
      tile_r[31:23] == 9'h000;
  endproperty
  a_tile_rsvd: assert property (p_tile_rsvd) else $error("tile reserved bits set");

  property p_stride_min;
    @(posedge mclk_i) disable iff (!rstn_i)
      tile_r[15:13] == 3'h0 |-> tile_stride_bytes_o == 15'h0400;
  endproperty
  a_stride_min: assert property (p_stride_min) else $error("stride code 0 not 1k");

  property p_stride_clamp;
    @(posedge mclk_i) disable iff (!rstn_i)
      tile_r[15:13] > 3'h4 |-> tile_stride_bytes_o == 15'h4000;
  endproperty
  a_stride_clamp: assert property (p_stride_clamp) else $error("stride not clamped");

  property p_fifo_rst;
    @(posedge mclk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == misc_regs_pkg::MISC_INIT_OFS |=>
        rst_host_fifo_o == $past(reg_wdata_i[1]);
  endproperty
  a_fifo_rst: assert property (p_fifo_rst) else $error("fifo reset does not follow write");

  property p_sub_rst;
    @(posedge mclk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == misc_regs_pkg::MISC_INIT_OFS |=>
        rst_sub_o == $past(reg_wdata_i[7:4]);
  endproperty
  a_sub_rst: assert property (p_sub_rst) else $error("subsystem resets wrong");

  property p_yorg;
    @(posedge mclk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == misc_regs_pkg::MISC_INIT_OFS |=>
        y_origin_o == $past(reg_wdata_i[29:18]);
  endproperty
  a_yorg: assert property (p_yorg) else $error("y origin does not follow write");

  property p_nor_sel;
    @(posedge mclk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == misc_regs_pkg::SPEED_MON_OFS |=>
        osc_nor_sel_o == $past(reg_wdata_i[29]);
  endproperty
  a_nor_sel: assert property (p_nor_sel) else $error("chain select wrong");

  property p_osc_hold;
    @(posedge mclk_i) disable iff (!rstn_i)
      !mon_en && !mon_r[misc_regs_pkg::OSC_CLR_BIT] &&
        !(reg_wr_i && reg_addr_i == misc_regs_pkg::SPEED_MON_OFS) |=>
        osc_cnt_r == $past(osc_cnt_r);
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("osc counter moved while off");

  property p_rd_unmapped;
    @(posedge mclk_i) disable iff (!rstn_i)
      reg_rd_i && reg_addr_i != misc_regs_pkg::SPEED_MON_OFS &&
        reg_addr_i != misc_regs_pkg::TILE_CFG_OFS &&
        reg_addr_i != misc_regs_pkg::MISC_INIT_OFS |=> reg_rdata_o == 32'h00000000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  c_osc_cnt: cover property (@(posedge mclk_i) disable iff (!rstn_i) osc_rise && mon_en);
  c_tile_wr: cover property (@(posedge mclk_i) disable iff (!rstn_i)
                             reg_wr_i && reg_addr_i == misc_regs_pkg::TILE_CFG_OFS);
  c_swz_both: cover property (@(posedge mclk_i) disable iff (!rstn_i) misc_r[3:2] == 2'b11);
  c_stride_clamp: cover property (@(posedge mclk_i) disable iff (!rstn_i) tile_r[15:13] > 3'h4);
  c_long_delay: cover property (@(posedge mclk_i) disable iff (!rstn_i)
                                misc_r[16:14] == 3'h7 && clk2x_en_i);
endmodule : init_misc_control_regs

// file: rtl/misc_regs_pkg.sv
package misc_regs_pkg;
  localparam logic [7:0]  SPEED_MON_OFS  = 8'h08;
  localparam logic [7:0]  TILE_CFG_OFS   = 8'h0c;
  localparam logic [7:0]  MISC_INIT_OFS  = 8'h10;
  localparam logic [31:0] SPEED_MON_RST  = 32'h40000000;
  localparam logic [31:0] TILE_CFG_RST   = 32'ha2200;
  localparam logic [31:0] MISC_INIT_RST  = 32'h00000000;
  localparam logic [31:0] TILE_CFG_MASK  = 32'h007fffff;
  localparam logic [31:0] MISC_INIT_MASK = 32'hfffdffff;
  localparam int          REF_LSB        = 0;
  localparam int          OSC_LSB        = 16;
  localparam int          OSC_CLR_BIT    = 28;
  localparam int          NOR_SEL_BIT    = 29;
  localparam int          MON_EN_BIT     = 30;
  localparam int          BEGIN_LSB      = 0;
  localparam int          STRIDE_LSB     = 13;
  localparam int          TILES_X_LSB    = 16;
  localparam int          RST_3D_BIT     = 0;
  localparam int          RST_FIFO_BIT   = 1;
  localparam int          REG_BSWZ_BIT   = 2;
  localparam int          REG_WSWZ_BIT   = 3;
  localparam int          RST_VID_BIT    = 4;
  localparam int          TV_BLANK_LSB   = 8;
  localparam int          TV_SYNC_LSB    = 11;
  localparam int          MON_SYNC_LSB   = 14;
  localparam int          YORG_LSB       = 18;
  localparam int          LFB_BSWZ_BIT   = 30;
  localparam int          LFB_WSWZ_BIT   = 31;
  localparam int          ADDR_3D_BIT    = 20;
  localparam int          ADDR_2D_BIT    = 19;
  localparam int          DELAY_BASE     = 2;
  localparam int          DELAY_MAX      = 9;
  localparam logic [10:0] STRIDE_1K      = 11'h001;
endpackage : misc_regs_pkg

// file: rtl/sync_delay_line.sv
module sync_delay_line #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  input  wire logic [2:0]   sel_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] tap_r   [misc_regs_pkg::DELAY_MAX];
  logic [W-1:0] tap_nxt [misc_regs_pkg::DELAY_MAX];

  // tap k holds the input delayed by k+1 enabled edges
  always_comb begin
    tap_nxt = tap_r;
    if (ce_i) begin
      tap_nxt[0] = d_i;
      for (int k = 1; k < misc_regs_pkg::DELAY_MAX; k++) tap_nxt[k] = tap_r[k-1];
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int k = 0; k < misc_regs_pkg::DELAY_MAX; k++) tap_r[k] <= '0;
    end else begin
      tap_r <= tap_nxt;
    end
  end

  // code 0 selects two flops, code 7 selects nine
  assign q_o = tap_r[32'(sel_i) + misc_regs_pkg::DELAY_BASE - 1];
endmodule : sync_delay_line

// file: test/init_misc_control_regs_tb.sv
module init_misc_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 0, rstn_i = 0, clk2x_en_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic        blank_i = 0, hsync_i = 0, vsync_i = 0;
  logic [7:0]  reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0, hw_wdata_i = '0, lfb_wdata_i = '0;
  logic [20:19] hw_addr_i = '0;
  logic [31:0] reg_rdata_o, hw_wdata_o, lfb_wdata_o;
  logic        tv_blank_o, tv_hsync_o, tv_vsync_o, mon_hsync_o, mon_vsync_o;
  logic        osc_nor_sel_o, rst_3d_o, rst_host_fifo_o, osc_nand, osc_nor;
  logic [12:0] tile_begin_page_o;
  logic [14:0] tile_stride_bytes_o;
  logic [6:0]  tiles_x_o;
  logic [3:0]  rst_sub_o;
  logic [11:0] y_origin_o;
  int          bad_count = 0, samples_checked = 0;
  logic [31:0] rd_a, rd_b;

  ring_osc_model osc (.mclk_i(mclk_i), .osc_nand_o(osc_nand), .osc_nor_o(osc_nor));
  init_misc_control_regs dut (.*, .osc_nand_i(osc_nand), .osc_nor_i(osc_nor));

  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    reg_rd_i <= 1; reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 0;
    #1 d = reg_rdata_o;
  endtask : rd

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  task automatic t_reset_values();
    rd(8'h08, rd_a); chk(rd_a & 32'hf000_0000, 32'h4000_0000);
    rd(8'h0c, rd_a); chk(rd_a, 32'h000a_2200);
    rd(8'h10, rd_a); chk(rd_a, 32'h0);
    rd(8'h04, rd_a); chk(rd_a, 32'h0);
    chk(tile_begin_page_o, 32'h200);
    chk(tile_stride_bytes_o, 32'h800);
    chk(tiles_x_o, 32'ha);
    $display("reset values done");
  endtask : t_reset_values

  task automatic t_tile();
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, rd_a); chk(rd_a, 32'h007f_ffff);
    chk(tile_begin_page_o, 32'h1fff);
    chk(tiles_x_o, 32'h7f);
    for (int c = 0; c < 6; c++) begin
      wr(8'h0c, 32'(c) << 13);
      #1 chk(tile_stride_bytes_o, (c > 4) ? 32'h4000 : 32'h400 << c);
    end
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, rd_a); chk(rd_a, 32'h0);
    $display("tile config done");
  endtask : t_tile

  task automatic t_misc();
    wr(8'h10, 32'h3ffd_00f3);
    #1 chk({rst_sub_o, rst_host_fifo_o, rst_3d_o}, 32'h3f);
    chk(y_origin_o, 32'hfff);
    rd(8'h10, rd_a); chk(rd_a, 32'h3ffd_00f3);
    wr(8'h10, 32'h0000_0050);
    #1 chk({rst_sub_o, rst_host_fifo_o, rst_3d_o}, 32'h14);
    $display("misc init done");
  endtask : t_misc

  task automatic swz(input logic [31:0] m, input logic [1:0] a, input logic [31:0] eh,
                     input logic [31:0] el);
    wr(8'h10, m);
    hw_addr_i <= a; hw_wdata_i <= 32'h1122_3344; lfb_wdata_i <= 32'h5566_7788;
    @(posedge mclk_i);
    #1 chk(hw_wdata_o, eh);
    chk(lfb_wdata_o, el);
  endtask : swz

  task automatic t_swizzle();
    swz(32'h0000_0004, 2'b10, 32'h4433_2211, 32'h5566_7788);
    swz(32'h4000_0004, 2'b01, 32'h4433_2211, 32'h8877_6655);
    swz(32'h8000_0008, 2'b01, 32'h3344_1122, 32'h7788_5566);
    swz(32'h0000_000c, 2'b10, 32'h2211_4433, 32'h5566_7788);
    swz(32'h0000_000c, 2'b00, 32'h1122_3344, 32'h5566_7788);
    $display("swizzle done");
  endtask : t_swizzle

  task automatic t_monitor();
    wr(8'h08, 32'h0);
    rd(8'h08, rd_a); repeat (20) @(posedge mclk_i);
    rd(8'h08, rd_b); chk(rd_b, rd_a);
    wr(8'h08, 32'h5000_0000); repeat (30) @(posedge mclk_i);
    rd(8'h08, rd_a); chk(rd_a[27:16], 32'h0);
    chk(rd_a[15:0] != 0, 32'h1);
    wr(8'h08, 32'h6000_0000); repeat (30) @(posedge mclk_i);
    chk(osc_nor_sel_o, 32'h1);
    rd(8'h08, rd_a); chk(rd_a[27:16] != 0, 32'h1);
    $display("speed monitor done");
  endtask : t_monitor

  function automatic logic tap(input int lsb);
    if (lsb == 8) return tv_blank_o;
    if (lsb == 11) return tv_hsync_o & tv_vsync_o;
    return mon_hsync_o & mon_vsync_o;
  endfunction : tap

  task automatic dly(input int lsb, input int n);
    wr(8'h10, 32'(n) << lsb);
    {blank_i, hsync_i, vsync_i} <= 3'b111;
    for (int k = 1; k <= n + 2; k++) begin
      @(posedge mclk_i);
      #1 if (k == n + 1) chk(tap(lsb), 32'h0);
    end
    chk(tap(lsb), 32'h1);
    {blank_i, hsync_i, vsync_i} <= 3'b000;
    repeat (12) @(posedge mclk_i);
  endtask : dly

  task automatic t_delay();
    for (int f = 0; f < 3; f++) begin
      dly(8 + 3 * f, 0);
      dly(8 + 3 * f, 7);
    end
    $display("delay lines done");
  endtask : t_delay

  initial begin
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1;
    t_reset_values();
    t_tile();
    t_misc();
    t_swizzle();
    t_monitor();
    t_delay();
    final_report();
  end

  // whole run needs well under 2000 cycles
  initial begin
    #(25 * 5000);
    bad_count++;
    final_report();
  end
endmodule : init_misc_control_regs_tb

// file: test/ring_osc_model.sv
// stands in for the two on-chip ring oscillators; both run well below mclk/2
// so the design's two-flop synchroniser never misses an edge
module ring_osc_model (
  input  wire logic mclk_i,
  output logic      osc_nand_o,
  output logic      osc_nor_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cyc_r = 0;
  initial begin
    osc_nand_o = 1'b0;
    osc_nor_o  = 1'b0;
  end
  always @(posedge mclk_i) begin
    cyc_r <= cyc_r + 1;
    if (cyc_r % 3 == 0) osc_nand_o <= ~osc_nand_o;
    if (cyc_r % 5 == 0) osc_nor_o <= ~osc_nor_o;
  end
endmodule : ring_osc_model
